// >>> hw/rpc_reset_clock_ctrl.sv
// Reset pin control and reference clock source selection
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: Reset pin is an input and an open-drain output pulling low.
// RL2: During power-up the pin is held driven low.
// RL3: After supplies stable keep pin low 100 us, then release.
// RL4: Watchdog and NMI watchdog resets also drive the pin low.
// RL5: Watchdog pulse lasts 512 main reference clock cycles.
// RL6: An outside circuit may pull the pin low to reset.
// RL7: Outside warm reset must stay low at least 3.2 us.
// RL8: With low power and divider above 16, minimum scales by divider/16.
// RL9: Boot pins must be held stable 1.5 ms after any reset.
// RL10: Sources: pin, watchdog, NMI watchdog, system, secure copy, hibernate.
// RL11: Secure copy and debugger resets do not pull the pin low.
// RL12: Boot pin drivers should stop on the pin's low level.
// RL13: Others should not drive boot pins actively.
// RL14: After any reset boot mode pins are sampled for branching.
// RL15: Internal oscillator one may clock watchdog and timer two.
// RL16: Crystal source may feed main PLL, aux PLL and timer two.
// RL17: Aux clock input may feed only aux PLL and timer two.
// RL18: Both PLL reference selects default to internal oscillator two.
// RL19: Pin stays low while any driving source is active, longest first.
module rpc_reset_clock_ctrl
   import rpc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic supplies_stable_i,
   input wire logic device_reset_pin_n_i,
   output logic device_reset_pin_n_o,
   output logic device_reset_pin_oe_o,
   input wire logic watchdog_reset_i,
   input wire logic nmi_watchdog_reset_i,
   input wire logic system_reset_i,
   input wire logic secure_copy_reset_i,
   input wire logic hibernate_reset_i,
   input wire logic debugger_reset_i,
   input wire logic main_reference_clock_tick_i,
   input wire logic low_power_used_i,
   input wire logic [7:0] system_clock_divider_i,
   input wire logic [3:0] boot_mode_pins_i,
   input wire logic [1:0] main_sel_i,
   input wire logic [1:0] aux_sel_i,
   input wire logic [1:0] wd_sel_i,
   input wire logic [1:0] tmr_sel_i,
   input wire logic sel_we_i,
   output logic core_reset_n_o,
   output logic [3:0] boot_mode_o,
   output logic boot_valid_o,
   output logic warm_short_o,
   output logic [1:0] main_reference_clock_sel_o,
   output logic [1:0] aux_reference_clock_sel_o,
   output logic [1:0] wd_clock_sel_o,
   output logic [1:0] tmr_clock_sel_o
);
   // ****************************************
   // Reset pin driver
   // ****************************************
   rpc_state_t state_r;
   logic [CNT_W-1:0] por_cnt_r;
   logic [9:0] wd_cnt_r;
   logic wd_req;
   logic pin_low_nxt;
   logic [CNT_W-1:0] boot_cnt_r;
   logic [CNT_W-1:0] ext_cnt_r;
   logic [CNT_W-1:0] ext_min;
   logic any_reset;

   assign wd_req = watchdog_reset_i | nmi_watchdog_reset_i; // see RL4

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= RPC_ST_POR;
         por_cnt_r <= '0;
      end else begin
         case (state_r)
            RPC_ST_POR: begin
               // Hold low until supplies settle
               if (supplies_stable_i) begin // see RL2
                  state_r <= RPC_ST_DRIVE;
               end
            end
            RPC_ST_DRIVE: begin
               if (por_cnt_r == CNT_W'(POR_PULSE_CYC - 1)) begin // see RL3
                  state_r <= RPC_ST_RUN;
               end
               por_cnt_r <= por_cnt_r + 1'b1;
            end
            RPC_ST_RUN: begin
               if (!supplies_stable_i) begin
                  state_r <= RPC_ST_POR;
                  por_cnt_r <= '0;
               end
            end
            default: begin
               state_r <= RPC_ST_POR;
            end
         endcase
      end
   end

   // Watchdog pulse counts main reference clock ticks, not core cycles
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wd_cnt_r <= '0;
      end else if (wd_req) begin
         wd_cnt_r <= 10'(WD_PULSE_OSC); // see RL5
      end else if (wd_cnt_r != '0 && main_reference_clock_tick_i) begin
         wd_cnt_r <= wd_cnt_r - 1'b1;
      end
   end

   // Secure copy and debugger resets never reach the pin
   assign pin_low_nxt = (state_r != RPC_ST_RUN) | wd_req
      | (wd_cnt_r != '0); // see RL11 RL19

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         device_reset_pin_oe_o <= 1'b1;
      end else begin
         device_reset_pin_oe_o <= pin_low_nxt; // see RL1
      end
   end
   assign device_reset_pin_n_o = 1'b0;

   // ****************************************
   // Reset source collection and boot sampling
   // ****************************************
   assign any_reset = !device_reset_pin_n_i | wd_req | system_reset_i
      | secure_copy_reset_i | hibernate_reset_i
      | debugger_reset_i; // see RL10 RL6

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_reset_n_o <= 1'b0;
      end else begin
         core_reset_n_o <= !(any_reset | pin_low_nxt);
      end
   end

   // Boot pins sampled at the end of the hold window after reset
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         boot_cnt_r <= '0;
         boot_valid_o <= 1'b0;
         boot_mode_o <= 4'h0;
      end else if (any_reset | pin_low_nxt) begin
         boot_cnt_r <= '0;
         boot_valid_o <= 1'b0;
      end else if (boot_cnt_r != CNT_W'(BOOT_HOLD_CYC)) begin // see RL9
         boot_cnt_r <= boot_cnt_r + 1'b1;
      end else if (!boot_valid_o) begin
         boot_mode_o <= boot_mode_pins_i; // see RL14
         boot_valid_o <= 1'b1;
      end
   end

   // Flags an outside warm reset shorter than the least width
   assign ext_min = (low_power_used_i
      && system_clock_divider_i > 8'(DIV_KNEE))
      ? CNT_W'((WARM_MIN_CYC * system_clock_divider_i) / DIV_KNEE)
      : CNT_W'(WARM_MIN_CYC); // see RL7 RL8

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_cnt_r <= '0;
         warm_short_o <= 1'b0;
      end else if (!device_reset_pin_n_i && !device_reset_pin_oe_o) begin
         if (ext_cnt_r != {CNT_W{1'b1}}) begin
            ext_cnt_r <= ext_cnt_r + 1'b1;
         end
      end else begin
         if (ext_cnt_r != '0 && ext_cnt_r < ext_min) begin
            warm_short_o <= 1'b1;
         end
         ext_cnt_r <= '0;
      end
   end

   // ****************************************
   // Reference clock source selection
   // ****************************************
   // Illegal pairings are refused and the old choice kept
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         main_reference_clock_sel_o <= MAIN_SEL_RST; // see RL18
         aux_reference_clock_sel_o <= AUX_SEL_RST; // see RL18
         wd_clock_sel_o <= WD_SEL_RST;
         tmr_clock_sel_o <= TMR_SEL_RST;
      end else if (sel_we_i) begin
         if (main_sel_i == RPC_SRC_OSC_TWO || main_sel_i == RPC_SRC_XTAL) begin
            main_reference_clock_sel_o <= main_sel_i; // see RL16
         end
         if (aux_sel_i != RPC_SRC_OSC_ONE) begin
            aux_reference_clock_sel_o <= aux_sel_i; // see RL17
         end
         if (wd_sel_i == RPC_SRC_OSC_ONE) begin
            wd_clock_sel_o <= wd_sel_i; // see RL15
         end
         tmr_clock_sel_o <= tmr_sel_i;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_por_hold;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_r == RPC_ST_POR) |=> device_reset_pin_oe_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("pin not low"); // see RL2

   property p_wd_drive;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      wd_req |=> device_reset_pin_oe_o && wd_cnt_r == 10'(WD_PULSE_OSC);
   endproperty
   a_wd_drive: assert property (p_wd_drive) else $error("wd no drive"); // see RL4

   property p_wd_len;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (wd_cnt_r != '0) |=> device_reset_pin_oe_o;
   endproperty
   a_wd_len: assert property (p_wd_len) else $error("wd pulse short"); // see RL5

   property p_scc_quiet;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_r == RPC_ST_RUN && wd_cnt_r == '0 && !wd_req)
         |=> !device_reset_pin_oe_o;
   endproperty
   a_scc_quiet: assert property (p_scc_quiet) else $error("pin pulled"); // see RL11

   sequence s_drive_end;
      state_r == RPC_ST_DRIVE && por_cnt_r == CNT_W'(POR_PULSE_CYC - 1);
   endsequence
   property p_por_len;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_drive_end |=> state_r == RPC_ST_RUN;
   endproperty
   a_por_len: assert property (p_por_len) else $error("por length"); // see RL3

   property p_main_legal;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      main_reference_clock_sel_o == RPC_SRC_OSC_TWO
         || main_reference_clock_sel_o == RPC_SRC_XTAL;
   endproperty
   a_main_legal: assert property (p_main_legal) else $error("main src"); // see RL16

   property p_aux_legal;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      aux_reference_clock_sel_o != RPC_SRC_OSC_ONE;
   endproperty
   a_aux_legal: assert property (p_aux_legal) else $error("aux src"); // see RL17

   property p_boot;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(boot_valid_o) |-> boot_mode_o == $past(boot_mode_pins_i);
   endproperty
   a_boot: assert property (p_boot) else $error("boot sample"); // see RL14
endmodule : rpc_reset_clock_ctrl
`default_nettype wire

// >>> hw/rpc_pkg.sv
// Package with reset pin and clock source selection constants
package rpc_pkg;
   // Core clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Power-on pulse after supplies are stable, microseconds
   localparam int unsigned POR_PULSE_US = 100;
   localparam int unsigned POR_PULSE_CYC =
      (POR_PULSE_US * 1000000) / CLK_PERIOD_PS;
   // Watchdog pulse in main reference clock cycles
   localparam int unsigned WD_PULSE_OSC = 512;
   // Least external warm reset, nanoseconds
   localparam int unsigned WARM_MIN_NS = 3200;
   localparam int unsigned WARM_MIN_CYC =
      (WARM_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Boot pin hold, microseconds
   localparam int unsigned BOOT_HOLD_US = 1500;
   localparam int unsigned BOOT_HOLD_CYC =
      (BOOT_HOLD_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W = 20;
   localparam int unsigned DIV_KNEE = 16;

   // Reference clock source codes
   typedef enum logic [1:0] {
      RPC_SRC_OSC_TWO = 2'h0,
      RPC_SRC_XTAL = 2'h1,
      RPC_SRC_OSC_ONE = 2'h2,
      RPC_SRC_AUX_IN = 2'h3
   } rpc_src_t;
   localparam rpc_src_t MAIN_SEL_RST = RPC_SRC_OSC_TWO;
   localparam rpc_src_t AUX_SEL_RST = RPC_SRC_OSC_TWO;
   localparam rpc_src_t WD_SEL_RST = RPC_SRC_OSC_ONE;
   localparam rpc_src_t TMR_SEL_RST = RPC_SRC_OSC_ONE;

   typedef enum logic [3:0] {
      RPC_ST_POR = 4'h1,
      RPC_ST_DRIVE = 4'h2,
      RPC_ST_RUN = 4'h4,
      RPC_ST_BOOT = 4'h8
   } rpc_state_t;
endpackage : rpc_pkg

// >>> dv/rpc_partner.sv
// Model of the outside supervisor, pin pull-up and boot pin driver
`timescale 1ns/1ps
`default_nettype none
module rpc_partner (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [10:0] len_i,
   input wire logic dev_oe_i,
   output logic pin_n_o,
   output logic tick_o,
   output logic [3:0] boot_o
);
   // ****
   // Pin and boot drivers
   // ****
   logic [10:0] cnt_r = '0;
   logic ph_r = 1'b0;
   // Pull-up wins unless a party sinks the pin
   assign pin_n_o = !(dev_oe_i || cnt_r != 11'h0);
   always @(posedge clk_i) begin
      ph_r <= !ph_r;
      // Pulse length is whatever the bench commands, short ones included
      if (go_i) begin
         cnt_r <= len_i;
      end else if (cnt_r != 11'h0) begin
         cnt_r <= cnt_r - 11'h1;
      end
   end
   assign tick_o = ph_r;
   // Backs off while the pin is low; pull-ups then read ones
   assign boot_o = pin_n_o ? 4'h5 : 4'hf;
endmodule : rpc_partner
`default_nettype wire

// >>> dv/rpc_reset_clock_ctrl_tb_top.sv
// Testbench for reset pin control and clock source selection
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
$display("ERROR %0t got %h exp %h", $time, a, b); end end
module rpc_reset_clock_ctrl_tb_top;
   import rpc_pkg::*;
   // ****
   // Stimulus and checks
   // ****
   logic clk = 1'b0, rst_b = 1'b0, stable = 1'b0, go = 1'b0, lp = 1'b0;
   logic we = 1'b0, we_d = 1'b0, pin_n, tick, oe, core_n, vld, shrt, dpn;
   logic [5:0] src = '0;
   logic [10:0] len = 11'h2bc;
   logic [7:0] dv = 8'h08;
   logic [3:0] boot, bmode;
   logic [1:0] mi = '0, ai = '0, wi = '0, ti = '0, ms, as, ws, ts;
   logic [1:0] em = 2'h0, ea = 2'h0, et = 2'h2;
   logic [7:0] exp_q[$];
   logic [31:0] r = 32'hd34a7fcb;
   int n_errors = 0, check_count = 0, cyc = 0, n, i;
   always #2.5 clk = ~clk;
   rpc_partner u_part (.clk_i(clk), .go_i(go), .len_i(len), .dev_oe_i(oe),
      .pin_n_o(pin_n), .tick_o(tick), .boot_o(boot));
   rpc_reset_clock_ctrl u_dut (.core_clk_i(clk), .rst_b_i(rst_b),
      .supplies_stable_i(stable), .device_reset_pin_n_i(pin_n),
      .device_reset_pin_n_o(dpn), .device_reset_pin_oe_o(oe),
      .watchdog_reset_i(src[0]), .nmi_watchdog_reset_i(src[1]),
      .system_reset_i(src[2]), .secure_copy_reset_i(src[3]),
      .hibernate_reset_i(src[4]), .debugger_reset_i(src[5]),
      .main_reference_clock_tick_i(tick), .low_power_used_i(lp),
      .system_clock_divider_i(dv), .boot_mode_pins_i(boot),
      .main_sel_i(mi), .aux_sel_i(ai), .wd_sel_i(wi), .tmr_sel_i(ti),
      .sel_we_i(we), .core_reset_n_o(core_n), .boot_mode_o(bmode),
      .boot_valid_o(vld), .warm_short_o(shrt),
      .main_reference_clock_sel_o(ms), .aux_reference_clock_sel_o(as),
      .wd_clock_sel_o(ws), .tmr_clock_sel_o(ts));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic warm(input logic [7:0] d, input logic l, input logic e);
      lp = l;
      dv = d;
      go = 1'b1;
      @(posedge clk);
      #1 go = 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK({pin_n, core_n}, 2'b00)
      repeat (720) @(posedge clk);
      #1 `CHK(shrt, e)
   endtask : warm
   // Selects show one edge after the write; checked from oldest note on
   always @(posedge clk) begin
      we_d <= we;
      cyc <= cyc + 1;
      if (we_d) begin
         `CHK({ms, as, ws, ts}, exp_q.pop_front())
      end
      // A clean run takes about 43600 cycles, two power-up pulses included
      if (cyc == 60000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 `CHK({oe, core_n, ms, as, ws, ts}, 10'h20a)
      `CHK({vld, shrt, bmode, dpn}, 7'h00)
      rst_b = 1'b1;
      stable = 1'b1;
      n = 0;
      while (oe === 1'b1 && n < 30000) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK(n inside {[20001:20003]}, 1'b1)
      // Core leaves reset one edge after the pin is seen high again
      @(posedge clk);
      #1 `CHK({core_n, vld, dpn}, 3'h4)
      for (i = 0; i < 24; i++) begin
         r = xs(r);
         if (r[7:6] < 2'h2) em = r[7:6];
         if (r[5:4] != 2'h2) ea = r[5:4];
         et = r[1:0];
         exp_q.push_back({em, ea, 2'h2, et});
         {mi, ai, wi, ti} = r[7:0];
         we = 1'b1;
         @(posedge clk);
         #1;
      end
      we = 1'b0;
      for (i = 0; i < 6; i++) begin
         src = 6'h1 << i;
         repeat (4) @(posedge clk);
         #1 `CHK({oe, core_n}, {i < 2, 1'b0})
         src = '0;
         n = 0;
         while (oe === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
         end
         if (i < 2) `CHK(n inside {[1020:1030]}, 1'b1)
         repeat (4) @(posedge clk);
         #1;
      end
      warm(8'h20, 1'b0, 1'b0);
      warm(8'h20, 1'b1, 1'b1);
      // Supplies dip in mid-run: pin goes low again for a full pulse
      stable = 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK({oe, core_n}, 2'b10)
      stable = 1'b1;
      n = 0;
      while (oe === 1'b1 && n < 30000) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK(n inside {[20001:20003]}, 1'b1)
      report_and_stop();
   end
endmodule : rpc_reset_clock_ctrl_tb_top
`default_nettype wire
